// ==== rtl/dtrc_pkg.sv ====
// package for the drive terminal run command logic
package dtrc_pkg;
    // terminal function codes
    localparam logic [7:0] FUNC_GO       = 8'h14; // 20
    localparam logic [7:0] FUNC_HALT     = 8'h15; // 21
    localparam logic [7:0] FUNC_DIR      = 8'h16; // 22
    localparam logic [7:0] FUNC_RAISE    = 8'h1B; // 27
    localparam logic [7:0] FUNC_LOWER    = 8'h1C; // 28
    localparam logic [7:0] FUNC_MEMCLR   = 8'h1D; // 29
    localparam logic [7:0] FUNC_OVERRIDE = 8'h1F; // 31
    // source selection values
    localparam logic [1:0] RUNSRC_TERM   = 2'h1;  // run source: terminal
    localparam logic [1:0] RUNSRC_KEYPAD = 2'h2;  // run source: keypad
    localparam logic [1:0] FREQSRC_KEYPAD = 2'h0; // freq source: keypad
    localparam logic [1:0] FREQSRC_OPER  = 2'h2;  // freq source: operator
    // frequency format and limits, 0.01 Hz units
    localparam int         FREQ_W        = 16;
    localparam logic [15:0] FREQ_MIN     = 16'h0000;
    // ramp step per tick of the ramp timebase
    localparam logic [15:0] RAMP_STEP    = 16'h0001;

    typedef struct packed {
        logic go;       // momentary go input
        logic haltHold; // halt hold, high while closed
        logic dirRev;   // direction select, high for reverse
        logic fwdRun;   // forward run terminal
        logic revRun;   // reverse run terminal
        logic raise;    // frequency raise input
        logic lower;    // frequency lower input
        logic memClr;   // raise/lower memory clear
        logic override; // keypad override input
        logic jog;      // jog in use
    } dtrc_term_type;

    typedef struct packed {
        logic       threeWire;  // three-wire control configured
        logic [1:0] runSrc;     // run command source selection
        logic [1:0] freqSrc;    // frequency source selection
        logic       retainMem;  // keep raise/lower value while stopped; a reset still clears it
    } dtrc_cfg_type;

    typedef struct packed {
        logic keyRun;   // keypad run key pulse
        logic keyStop;  // keypad stop key pulse
        logic keyRev;   // keypad direction, high for reverse
    } dtrc_key_type;

    typedef enum {
        ST_IDLE,
        ST_RUN,
        ST_OVR_STOP
    } dtrc_state_type;
endpackage

// ==== rtl/dtrc_run_logic.sv ====
// run and speed command logic behind the multi-function input terminals
`timescale 1ns/100ps
// How it works
// - functions 20 go, 21 halt hold, 22 direction select are provided
// - go starts only on an off-to-on edge, using the accel ramp
// - halt hold is active low level; off stops via decel ramp
// - direction select is a level; high reverse, low forward, except during a forced stop
// - three-wire mode ignores forward run and reverse run terminals
// - raise/lower ramps use the normal accel and decel times
// - raise on accelerates from present value, off holds value reached
// - lower on decelerates from present value, off holds value reached
// - retention off restores the frequency before raise/lower adjustment
// - memory clear on drops adjustment and returns to set frequency
// - raise/lower works only with frequency source set to operator
// - raise/lower is disabled while jog is in use
// - adjusted frequency clamps between zero and maximum frequency
// - adjustment starts from the stored output frequency setting
// - override on gives keypad both frequency and run command
// - override change while driving first stops the motor
// - keypad run with override on while running stops the motor first
module dtrc_run_logic
    import dtrc_pkg::*;
(
    input  wire logic          clk_sys,     // 100 MHz system clock
    input  wire logic          resetn,      // async reset, active low
    input  wire dtrc_term_type term,        // input terminal levels
    input  wire dtrc_cfg_type  cfg,         // configuration settings
    input  wire dtrc_key_type  key,         // keypad commands
    input  wire logic [15:0]   setFreq,     // stored output freq setting
    input  wire logic [15:0]   keyFreq,     // keypad frequency reference
    input  wire logic [15:0]   extFreq,     // configured source reference
    input  wire logic [15:0]   maxFreq,     // maximum frequency setting
    input  wire logic          accelTick,   // accel ramp timebase pulse
    input  wire logic          decelTick,   // decel ramp timebase pulse
    input  wire logic          motorStopped,// ramp reports zero output
    output logic               runCmd,      // run request to the ramp
    output logic               revCmd,      // reverse direction request
    output logic [15:0]        freqRef,     // frequency reference out
    output logic               keypadActive // override in effect
);

    // reset release chain
    logic           rstSync1Ff;
    logic           rstSync2Ff;
    // run, direction and override state
    logic           goPrevFf;
    logic           runFf;
    logic           nxt_run;
    logic           revFf;
    logic           nxt_rev;
    logic           ovrFf;          // override state in effect
    // raise/lower working state and the reference
    logic [15:0]    adjFreqFf;      // raise/lower working value
    logic [15:0]    nxt_adjFreq;
    logic           adjValidFf;     // adjustment in effect
    logic           nxt_adjValid;
    logic [15:0]    freqRefFf;
    // sequencer for forced stops
    dtrc_state_type stateFf;
    dtrc_state_type nxt_state;
    // decoded edges, enables and requests
    logic           rstN;
    logic           goEdge;
    logic           ovrChange;
    logic           adjEnable;
    logic           termRun;
    logic           termRev;
    logic           wantRun;
    logic           wantRev;

    // reset release through two flops
    // entry is immediate, exit is clocked, so every flop below
    // leaves reset on the same edge; rstN clears the rest
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rstSync1Ff <= 1'b0;
            rstSync2Ff <= 1'b0;
        end else begin
            rstSync1Ff <= 1'b1;
            rstSync2Ff <= rstSync1Ff;
        end
    end
    assign rstN = rstSync2Ff;

    // go edge detect; starts at high so a held switch at reset is no edge
    // a start needs a fresh closure of the momentary contact
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            goPrevFf <= 1'b1;
        end else begin
            goPrevFf <= term.go;
        end
    end
    assign goEdge = term.go && !goPrevFf;

    // terminal-side run request and direction
    // in three-wire mode the request is latched here: go sets it,
    // an open halt contact clears it, and the open contact wins
    always_comb begin
        termRun = runFf;
        termRev = revFf;
        if (cfg.threeWire) begin
            // forward and reverse run terminals have no say here
            termRev = term.dirRev;
            if (!term.haltHold) begin
                termRun = 1'b0;
            end else if (goEdge) begin
                termRun = 1'b1;
            end
        end else begin
            // two-wire levels; both on reads as stop
            termRun = term.fwdRun ^ term.revRun;
            termRev = term.revRun;
        end
    end

    // pick the source of run command: keypad under override
    // keypad stop beats keypad run when both come together;
    // other run source codes leave the request where it was
    always_comb begin
        wantRun = runFf;
        wantRev = revFf;
        if (ovrFf) begin
            if (key.keyStop) begin
                wantRun = 1'b0;
            end else if (key.keyRun) begin
                wantRun = 1'b1;
            end
            wantRev = key.keyRev;
        end else if (cfg.runSrc == RUNSRC_KEYPAD) begin
            if (key.keyStop) begin
                wantRun = 1'b0;
            end else if (key.keyRun) begin
                wantRun = 1'b1;
            end
            wantRev = key.keyRev;
        end else if (cfg.runSrc == RUNSRC_TERM) begin
            // terminal source: three-wire or two-wire request
            wantRun = termRun;
            wantRev = termRev;
        end
    end

    // override pin differs from the override in effect
    assign ovrChange = term.override != ovrFf;

    // sequencing of override changes and keypad takeover
    // a forced stop is held until the ramp reports standstill;
    // only then may the new override state or a start follow
    always_comb begin
        nxt_state = stateFf;
        nxt_run   = wantRun;
        nxt_rev   = wantRev;
        unique case (stateFf)
            ST_IDLE: begin
                // a pending override change lands before any new start
                if (ovrChange) begin
                    nxt_run = 1'b0;
                end else if (nxt_run) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (ovrChange) begin
                    nxt_run   = 1'b0;
                    nxt_rev   = revFf;
                    nxt_state = ST_OVR_STOP;
                end else if (ovrFf && key.keyRun && !key.keyStop) begin
                    // keypad run while running: stop, then keypad rules
                    nxt_run   = 1'b0;
                    nxt_rev   = revFf;
                    nxt_state = ST_OVR_STOP;
                end else if (!nxt_run) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_OVR_STOP: begin
                // hold stop until the ramp reaches standstill
                nxt_run = 1'b0;
                nxt_rev = revFf;
                if (motorStopped) begin
                    nxt_state = ST_IDLE;
                end
            end
        endcase
    end

    // run state and direction registers
    // direction holds during a forced stop so decel is not reversed
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            stateFf <= ST_IDLE;
            runFf   <= 1'b0;
            revFf   <= 1'b0;
        end else begin
            stateFf <= nxt_state;
            runFf   <= nxt_run;
            revFf   <= nxt_rev;
        end
    end

    // override takes effect only once the motor is not being driven
    // limitation: an override pulse that ends before the motor
    // has stopped is not seen, since the change then vanishes
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            ovrFf <= 1'b0;
        end else if (ovrChange && stateFf != ST_RUN && motorStopped) begin
            ovrFf <= term.override;
        end
    end

    // raise/lower allowed only from operator source and not during jog
    // the keypad override freezes the adjustment as well
    assign adjEnable = (cfg.freqSrc == FREQSRC_OPER) && !term.jog
                       && !ovrFf;

    // raise/lower working value and clamp
    // the working value starts from the stored setting and moves
    // one step per tick; raise with lower together is no change,
    // and memory clear overrides both
    always_comb begin
        nxt_adjFreq  = adjFreqFf;
        nxt_adjValid = adjValidFf;
        if (!adjValidFf) begin
            nxt_adjFreq = setFreq;
        end
        if (term.memClr) begin
            nxt_adjFreq  = setFreq;
            nxt_adjValid = 1'b0;
        end else if (adjEnable && term.raise && !term.lower) begin
            nxt_adjValid = 1'b1;
            // accel tick paces the climb like a normal start
            // headroom is tested first, so the add cannot wrap
            if (accelTick) begin
                if (nxt_adjFreq >= maxFreq
                    || maxFreq - nxt_adjFreq < RAMP_STEP) begin
                    nxt_adjFreq = maxFreq;
                end else begin
                    nxt_adjFreq = nxt_adjFreq + RAMP_STEP;
                end
            end
        end else if (adjEnable && term.lower && !term.raise) begin
            nxt_adjValid = 1'b1;
            // decel tick paces the fall like a normal stop
            if (decelTick) begin
                if (nxt_adjFreq - FREQ_MIN < RAMP_STEP) begin
                    nxt_adjFreq = FREQ_MIN;
                end else begin
                    nxt_adjFreq = nxt_adjFreq - RAMP_STEP;
                end
            end
        end
        // a lowered maximum pulls a held value down too
        if (nxt_adjFreq > maxFreq) begin
            nxt_adjFreq = maxFreq;
        end
    end

    // working value; kept whatever the retention setting, which only picks the reference
    // the value lives only in flops, so a reset clears it; the
    // retention setting therefore only covers stopped periods
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            adjFreqFf  <= FREQ_MIN;
            adjValidFf <= 1'b0;
        end else begin
            adjFreqFf  <= nxt_adjFreq;
            adjValidFf <= nxt_adjValid;
        end
    end

    // frequency reference selection; retention decides if the value applies while stopped
    // retention off: the adjusted value applies only while running,
    // and the stored setting returns as soon as the run request drops
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            freqRefFf <= FREQ_MIN;
        end else if (ovrFf || cfg.freqSrc == FREQSRC_KEYPAD) begin
            freqRefFf <= keyFreq;
        end else if (cfg.freqSrc == FREQSRC_OPER) begin
            if (adjValidFf && (cfg.retainMem || runFf)) begin
                freqRefFf <= adjFreqFf;
            end else begin
                freqRefFf <= setFreq;
            end
        end else begin
            // other source codes take the external reference
            freqRefFf <= extFreq;
        end
    end

    // outputs come straight from flops
    assign runCmd       = runFf;
    assign revCmd       = revFf;
    assign freqRef      = freqRefFf;
    assign keypadActive = ovrFf;

endmodule

// ==== sim/dtrc_run_checker.sv ====
// assertions on the run logic ports
`timescale 1ns/100ps
module dtrc_run_checker
    import dtrc_pkg::*;
(
    input wire logic          clk_sys,      // clock
    input wire logic          resetn,       // reset, active low
    input wire dtrc_term_type term,         // terminals
    input wire dtrc_cfg_type  cfg,          // settings
    input wire logic [15:0]   setFreq,      // stored setting
    input wire logic [15:0]   maxFreq,      // upper limit
    input wire logic          motorStopped, // ramp at zero
    input wire logic          runCmd,       // run request
    input wire logic          revCmd,       // reverse request
    input wire logic [15:0]   freqRef,      // reference out
    input wire logic          keypadActive  // override in effect
);
    logic tw;
    logic op;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // terminal three-wire control, no override in play
    assign tw = cfg.threeWire && cfg.runSrc == RUNSRC_TERM
        && !term.override && !keypadActive;
    // raise/lower allowed while running
    assign op = tw && cfg.freqSrc == FREQSRC_OPER && !term.jog
        && !term.memClr && runCmd;
    a_go_starts: assert property (tw && term.haltHold && $rose(term.go)
        ##1 tw && term.haltHold |-> ##[0:1] runCmd)
        else $error("go edge gave no run");
    a_halt_stops: assert property (tw && !term.haltHold
        ##1 !term.haltHold |-> !runCmd) else $error("run during halt");
    a_dir_level: assert property (tw && runCmd && $stable(term.dirRev)
        ##1 runCmd && $stable(term.dirRev) |-> revCmd == term.dirRev)
        else $error("direction not followed");
    a_fwd_ignored: assert property ((tw && !runCmd && !term.go)[*2]
        |=> !runCmd) else $error("run without go edge");
    a_clamp_max: assert property ((op && $stable(maxFreq))[*3]
        |-> freqRef <= maxFreq) else $error("reference above max");
    a_hold_freq: assert property ((op && !term.raise && !term.lower
        && $stable(setFreq))[*4] |-> $stable(freqRef))
        else $error("reference drifted");
    a_raise_up: assert property ((op && term.raise && !term.lower
        && $stable(setFreq))[*4] |-> freqRef >= $past(freqRef))
        else $error("raise lowered reference");
    a_ovr_stops: assert property (runCmd && $changed(term.override)
        |-> ##[1:2] !runCmd) else $error("override change kept run");
    a_ovr_waits: assert property ($changed(keypadActive) |-> !runCmd
        && ($past(motorStopped) || $past(motorStopped, 2)))
        else $error("override took effect while moving");
endmodule

// ==== sim/dtrc_ramp_model.sv ====
// ramp model: step pulses and stop status for the run logic
`timescale 1ns/100ps
module dtrc_ramp_model #(
    parameter int STOP_LAG = 8
) (
    input  wire logic clk_sys,      // system clock
    input  wire logic resetn,       // async reset, active low
    input  wire logic runCmd,       // run request
    output logic      accelTick,    // accel step pulse
    output logic      decelTick,    // decel step pulse
    output logic      motorStopped  // output at zero
);
    logic [1:0] div_ff;
    logic [7:0] lag_ff;
    // one step each way per four cycles, same pacing as normal ramps
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) div_ff <= 2'h0;
        else div_ff <= div_ff + 2'h1;
    end
    assign accelTick = div_ff == 2'h3;
    assign decelTick = div_ff == 2'h1;
    // coasting takes time, so zero is reported only after a lag
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) lag_ff <= 8'h00;
        else if (runCmd) lag_ff <= 8'h00;
        else if (lag_ff != STOP_LAG[7:0]) lag_ff <= lag_ff + 8'h01;
    end
    assign motorStopped = !runCmd && lag_ff == STOP_LAG[7:0];
endmodule

// ==== sim/dtrc_run_logic_test.sv ====
// self-checking bench for the terminal run command logic
`timescale 1ns/100ps
module dtrc_run_logic_test;
    import dtrc_pkg::*;
    typedef struct packed {
        logic raise, lower, jog;
        logic [1:0] fsrc;
        logic [15:0] base, dir;
    } dtrc_row_type;
    dtrc_row_type rows [5] = '{
        '{1'b1, 1'b0, 1'b0, FREQSRC_OPER, 16'h0100, 16'h0001},
        '{1'b0, 1'b1, 1'b0, FREQSRC_OPER, 16'h0100, 16'h0002},
        '{1'b1, 1'b1, 1'b0, FREQSRC_OPER, 16'h0100, 16'h0000},
        '{1'b1, 1'b0, 1'b0, 2'h3, 16'h0200, 16'h0000},
        '{1'b1, 1'b0, 1'b1, FREQSRC_OPER, 16'h0100, 16'h0000}};
    logic clk_sys, resetn, accelTick, decelTick, motorStopped;
    logic runCmd, revCmd, keypadActive;
    logic [15:0] setFreq, keyFreq, extFreq, maxFreq, freqRef;
    dtrc_term_type term;
    dtrc_cfg_type cfg;
    dtrc_key_type key;
    int nMismatch = 0;
    int numChecks = 0;
    dtrc_run_logic dut (.clk_sys(clk_sys), .resetn(resetn), .term(term),
        .cfg(cfg), .key(key), .setFreq(setFreq), .keyFreq(keyFreq),
        .extFreq(extFreq), .maxFreq(maxFreq), .accelTick(accelTick),
        .decelTick(decelTick), .motorStopped(motorStopped),
        .runCmd(runCmd), .revCmd(revCmd), .freqRef(freqRef),
        .keypadActive(keypadActive));
    dtrc_ramp_model rmp (.clk_sys(clk_sys), .resetn(resetn),
        .runCmd(runCmd), .accelTick(accelTick), .decelTick(decelTick),
        .motorStopped(motorStopped));
    task automatic wt(int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        numChecks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", numChecks, nMismatch);
        if (nMismatch == 0 && numChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // a clean off-to-on go edge
    task automatic go;
        term.go = 1'b0;
        wt(2);
        term.go = 1'b1;
        wt(3);
        term.go = 1'b0;
        wt(2);
    endtask
    function automatic logic [15:0] cls(logic [15:0] b);
        if (freqRef === b) return 16'h0000;
        return (freqRef > b) ? 16'h0001 : 16'h0002;
    endfunction
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // cut a hang short well past the expected run length
    initial begin
        repeat (5000) @(posedge clk_sys);
        nMismatch++;
        wrap_up();
    end
    initial begin
        term = '0;
        key = '0;
        resetn = 1'b0;
        setFreq = 16'h0100;
        keyFreq = 16'h0300;
        extFreq = 16'h0200;
        maxFreq = 16'h0F00;
        cfg = '0;
        cfg.threeWire = 1'b1;
        cfg.runSrc = RUNSRC_TERM;
        cfg.freqSrc = FREQSRC_OPER;
        term.haltHold = 1'b1;
        term.go = 1'b1;
        wt(6);
        chk("reset run", {15'h0, runCmd}, 16'h0000);
        resetn = 1'b1;
        wt(5);
        chk("go held", {15'h0, runCmd}, 16'h0000);
        foreach (rows[i]) begin
            cfg.freqSrc = rows[i].fsrc;
            term.jog = rows[i].jog;
            term.memClr = 1'b1;
            wt(3);
            term.memClr = 1'b0;
            go();
            term.raise = rows[i].raise;
            term.lower = rows[i].lower;
            wt(40);
            term.raise = 1'b0;
            term.lower = 1'b0;
            wt(3);
            chk("ramp dir", cls(rows[i].base), rows[i].dir);
            $display("row %0d done", i);
        end
        cfg.freqSrc = FREQSRC_OPER;
        term.jog = 1'b0;
        term.memClr = 1'b1;
        wt(3);
        term.memClr = 1'b0;
        go();
        maxFreq = 16'h0104;
        term.raise = 1'b1;
        wt(60);
        chk("clamp", freqRef, 16'h0104);
        term.raise = 1'b0;
        term.memClr = 1'b1;
        wt(4);
        chk("mem clear", freqRef, 16'h0100);
        term.memClr = 1'b0;
        term.dirRev = 1'b1;
        wt(4);
        chk("dir rev", {15'h0, revCmd}, 16'h0001);
        term.dirRev = 1'b0;
        wt(4);
        chk("dir fwd", {15'h0, revCmd}, 16'h0000);
        $display("speed tests done");
        term.go = 1'b1;
        term.haltHold = 1'b0;
        wt(4);
        chk("halt", {15'h0, runCmd}, 16'h0000);
        term.go = 1'b0;
        wt(2);
        term.go = 1'b1;
        wt(4);
        chk("go in halt", {15'h0, runCmd}, 16'h0000);
        term.haltHold = 1'b1;
        wt(4);
        chk("no edge", {15'h0, runCmd}, 16'h0000);
        term.go = 1'b0;
        term.fwdRun = 1'b1;
        wt(4);
        chk("fwd pin", {15'h0, runCmd}, 16'h0000);
        term.fwdRun = 1'b0;
        term.revRun = 1'b1;
        wt(4);
        chk("rev pin", {15'h0, runCmd}, 16'h0000);
        term.revRun = 1'b0;
        go();
        chk("restart", {15'h0, runCmd}, 16'h0001);
        $display("start stop tests done");
        term.override = 1'b1;
        wt(2);
        chk("ovr stop", {15'h0, runCmd}, 16'h0000);
        wt(30);
        chk("ovr on", {15'h0, keypadActive}, 16'h0001);
        key.keyRun = 1'b1;
        wt(1);
        key.keyRun = 1'b0;
        wt(4);
        chk("key run", {15'h0, runCmd}, 16'h0001);
        chk("key freq", freqRef, keyFreq);
        key.keyRun = 1'b1;
        wt(1);
        key.keyRun = 1'b0;
        wt(2);
        chk("key rerun", {15'h0, runCmd}, 16'h0000);
        wt(12);
        key.keyRev = 1'b1;
        key.keyRun = 1'b1;
        wt(1);
        key.keyRun = 1'b0;
        wt(2);
        chk("key rev", {15'h0, revCmd}, 16'h0001);
        key.keyStop = 1'b1;
        wt(1);
        key.keyStop = 1'b0;
        wt(2);
        chk("key stop", {15'h0, runCmd}, 16'h0000);
        $display("override tests done");
        // reset after the keypad stop: outputs clear, a held go is no start
        resetn = 1'b0;
        term.override = 1'b0;
        term.go = 1'b1;
        wt(2);
        chk("rst run", {15'h0, runCmd}, 16'h0000);
        chk("rst ovr", {15'h0, keypadActive}, 16'h0000);
        resetn = 1'b1;
        wt(5);
        chk("rst go held", {15'h0, runCmd}, 16'h0000);
        chk("rst freq", freqRef, setFreq);
        go();
        chk("rst restart", {15'h0, runCmd}, 16'h0001);
        term.raise = 1'b1;
        wt(12);
        term.raise = 1'b0;
        term.haltHold = 1'b0;
        wt(4);
        chk("no retain", cls(setFreq), 16'h0000);
        cfg.retainMem = 1'b1;
        wt(3);
        chk("retain", cls(setFreq), 16'h0001);
        $display("reset and retention tests done");
        wrap_up();
    end
endmodule
bind dtrc_run_logic dtrc_run_checker chk (.clk_sys(clk_sys),
    .resetn(resetn), .term(term), .cfg(cfg), .setFreq(setFreq),
    .maxFreq(maxFreq), .motorStopped(motorStopped), .runCmd(runCmd),
    .revCmd(revCmd), .freqRef(freqRef), .keypadActive(keypadActive));
